// ===== motor_state_flags.sv
// Drive state word: latched fault flags, bridge float, write guards, PWM tick
// Notes on behaviour
// RULE_01 - Config write while running: ignored, error set
// RULE_02 - Sixteen-bit state word, fixed bit order
// RULE_03 - Float flag; motion and halts exit unless forced
// RULE_04 - Lockout flag active low, low after reset
// RULE_05 - ADC undervoltage flag active low on event
// RULE_06 - Overcurrent flag active low on event
// RULE_07 - Separate active-low stall flags per bridge
// RULE_08 - Bad-command flag set on undefined/unperformable command
// RULE_09 - Switch level: low open, high closed
// RULE_10 - Switch event set on switch input falling edge
// RULE_11 - Thermal bits: normal, warning, bridge off, device off
// RULE_12 - Fault flags latched until state-read command
// RULE_13 - Busy bit follows busy pin, low while executing
// RULE_14 - Step flag high in external step mode
// RULE_15 - Direction bit: one forward, zero reverse
// RULE_16 - Phase bits: stopped, accel, decel, constant
// RULE_17 - State word writes ignored, error set
// RULE_18 - 16 MHz oscillator: 62.5 down to 2.8 kHz
// RULE_19 - 24 MHz oscillator: 93.8 down to 4.2 kHz
// RULE_20 - 32 MHz oscillator: 125.0 down to 5.6 kHz
// RULE_21 - Integer code gives divider code plus one, max seven
// RULE_22 - Multiplier codes give 0.625 up to 2
// RULE_23 - Read returns word before clear, then release
`include "motor_state_defs.svh"
`default_nettype none

module motor_state_flags
  import motor_state_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire cmd_req_t   cmd_req,
  input  wire engine_in_t engine,
  input  wire logic       limit_switch_input,
  input  wire logic       step_pulse_input,
  output logic [15:0]     state_word,
  output logic [15:0]     read_data,
  output logic            read_valid,
  output logic            config_accept,
  output logic [2:0]      pwm_int_code,
  output logic [2:0]      pwm_fraction_multiplier,
  output logic            pwm_tick,
  output logic            step_tick,
  output logic            bridges_floating
);

  typedef struct packed {
    logic        sw_meta;
    logic        sw_sync;
    logic        sw_prev;
    logic        stp_meta;
    logic        stp_sync;
    logic        stp_prev;
    logic        supply_lockout_flag_n;
    logic        adc_undervolt_flag_n;
    logic        overcurrent_flag_n;
    logic        stall_a_n;
    logic        stall_b_n;
    logic        cmd_err;
    logic        switch_close_event;
    thermal_t    thermal_state;
    logic        floating;
    logic [2:0]  pwm_int;
    logic [2:0]  pwm_dec;
    logic [15:0] pwm_acc;
    logic        pwm_tick;
    logic        step_tick;
    logic [15:0] word;
    logic [15:0] rdata;
    logic        rvalid;
    logic        cfg_acc;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic        is_read;
  logic        is_cfg;
  logic        running;
  logic        bad_cmd;
  logic        exit_float;
  logic        sw_fall;
  logic [15:0] mult8;
  logic [15:0] limit;
  logic [15:0] acc_sum;

  // Multiplier as eighths so the tick accumulator stays integer
  function automatic logic [15:0] mult_eighths(input logic [2:0] code);
    logic [15:0] m;
    m = 16'h0005;
    unique case (code)
      3'h0: m = 16'h0005;
      3'h1: m = 16'h0006;
      3'h2: m = 16'h0007;
      3'h3: m = 16'h0008;
      3'h4: m = 16'h000a;
      3'h5: m = 16'h000c;
      3'h6: m = 16'h000e;
      3'h7: m = 16'h0010;
    endcase
    return m;
  endfunction : mult_eighths

  function automatic logic [15:0] int_factor(input logic [2:0] code);
    logic [2:0] c;
    c = (code > `PWM_INT_MAX_CODE) ? `PWM_INT_MAX_CODE : code;
    return {13'h0000, c} + 16'h0001;
  endfunction : int_factor

  always_comb begin
    st_nxt  = st_r;
    is_read = cmd_req.valid && cmd_req.kind == CMD_READ_STATE;
    is_cfg  = cmd_req.valid && cmd_req.kind == CMD_WRITE_CONFIG;
    running = engine.phase != PH_STOPPED;
    // Command errors: unknown, not performable, guarded writes
    bad_cmd = cmd_req.valid &&
              (cmd_req.kind == CMD_UNDEFINED ||
               cmd_req.kind == CMD_BLOCKED) ; // [RULE_08]
    bad_cmd = bad_cmd || (is_cfg && running); // [RULE_01]
    bad_cmd = bad_cmd ||
              (cmd_req.valid && cmd_req.kind == CMD_WRITE_STATE); // [RULE_17]
    exit_float = cmd_req.valid &&
                 (cmd_req.kind == CMD_MOTION || cmd_req.kind == CMD_HALT);

    // Two-stage synchronisers for the pins
    st_nxt.sw_meta  = limit_switch_input;
    st_nxt.sw_sync  = st_r.sw_meta;
    st_nxt.sw_prev  = st_r.sw_sync;
    st_nxt.stp_meta = step_pulse_input;
    st_nxt.stp_sync = st_r.stp_meta;
    st_nxt.stp_prev = st_r.stp_sync;
    sw_fall = st_r.sw_prev && !st_r.sw_sync; // [RULE_10]
    st_nxt.step_tick = engine.ext_step_mode &&
                       st_r.stp_sync && !st_r.stp_prev; // [RULE_14]

    // Clear on read first, then new events win over the clear
    if (is_read) begin // [RULE_12] [RULE_23]
      st_nxt.supply_lockout_flag_n = 1'b1;
      st_nxt.adc_undervolt_flag_n  = 1'b1;
      st_nxt.overcurrent_flag_n    = 1'b1;
      st_nxt.stall_a_n             = 1'b1;
      st_nxt.stall_b_n             = 1'b1;
      st_nxt.cmd_err               = 1'b0;
      st_nxt.switch_close_event    = 1'b0;
      st_nxt.thermal_state         = engine.thermal;
    end else if (engine.thermal > st_r.thermal_state) begin
      st_nxt.thermal_state = engine.thermal; // [RULE_11] [RULE_12]
    end
    if (engine.lockout_evt) st_nxt.supply_lockout_flag_n = 1'b0; // [RULE_04]
    if (engine.adc_uv_evt)  st_nxt.adc_undervolt_flag_n = 1'b0;  // [RULE_05]
    if (engine.ocd_evt)     st_nxt.overcurrent_flag_n = 1'b0;    // [RULE_06]
    if (engine.stall_a_evt) st_nxt.stall_a_n = 1'b0;             // [RULE_07]
    if (engine.stall_b_evt) st_nxt.stall_b_n = 1'b0;             // [RULE_07]
    if (bad_cmd)            st_nxt.cmd_err = 1'b1;               // [RULE_08]
    if (sw_fall)            st_nxt.switch_close_event = 1'b1;    // [RULE_10]

    // Bridge float: error forcing outranks any motion command
    if (engine.force_float) begin
      st_nxt.floating = 1'b1; // [RULE_03]
    end else if (exit_float) begin
      st_nxt.floating = 1'b0; // [RULE_03]
    end else if (cmd_req.valid && cmd_req.kind == CMD_FLOAT) begin
      st_nxt.floating = 1'b1;
    end

    // Config write only while stopped; state word itself is never written
    st_nxt.cfg_acc = is_cfg && !running; // [RULE_01] [RULE_17]
    if (is_cfg && !running) begin
      st_nxt.pwm_int = cmd_req.data[`CFG_PWM_INT_LO +: 3];
      st_nxt.pwm_dec = cmd_req.data[`CFG_PWM_DEC_LO +: 3];
    end

    // Tick rate = clock / (512 * N) * M, with M in eighths
    mult8   = mult_eighths(st_r.pwm_dec); // [RULE_22]
    limit   = 16'((`PWM_BASE_DIV * `PWM_MULT_DEN) *
                  int_factor(st_r.pwm_int)); // [RULE_21]
    acc_sum = st_r.pwm_acc + mult8;
    st_nxt.pwm_tick = 1'b0;
    if (st_nxt.cfg_acc) begin
      // Restart so a shorter period never leaves the sum past its limit
      st_nxt.pwm_acc = 16'h0000;
    end else if (acc_sum >= limit) begin
      st_nxt.pwm_acc  = acc_sum - limit; // [RULE_18] [RULE_19] [RULE_20]
      st_nxt.pwm_tick = 1'b1;
    end else begin
      st_nxt.pwm_acc = acc_sum;
    end

    // Snapshot taken from the word before this cycle's clear
    st_nxt.rvalid = is_read;
    if (is_read) st_nxt.rdata = st_r.word; // [RULE_23]

    st_nxt.word = {st_nxt.stall_b_n, st_nxt.stall_a_n,
                   st_nxt.overcurrent_flag_n, st_nxt.thermal_state,
                   st_nxt.adc_undervolt_flag_n,
                   st_nxt.supply_lockout_flag_n,
                   engine.ext_step_mode, st_nxt.cmd_err, engine.phase,
                   engine.dir_fwd, st_nxt.switch_close_event,
                   !st_r.sw_sync, engine.busy_n,
                   st_nxt.floating}; // [RULE_02] [RULE_09] [RULE_13]
    // [RULE_14] [RULE_15] [RULE_16] ride in the word above
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r                       <= '0;
      // Open-switch idle level, so no false closed level after reset
      st_r.sw_meta               <= 1'b1;
      st_r.sw_sync               <= 1'b1;
      st_r.sw_prev               <= 1'b1;
      st_r.supply_lockout_flag_n <= 1'b0; // [RULE_04]
      st_r.adc_undervolt_flag_n  <= 1'b1;
      st_r.overcurrent_flag_n    <= 1'b1;
      st_r.stall_a_n             <= 1'b1;
      st_r.stall_b_n             <= 1'b1;
      st_r.floating              <= 1'b1;
      st_r.pwm_int               <= `PWM_INT_RST;
      st_r.pwm_dec               <= `PWM_DEC_RST;
      st_r.word                  <= `STATE_WORD_RST; // [RULE_04]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign state_word              = st_r.word;
  assign read_data               = st_r.rdata;
  assign read_valid              = st_r.rvalid;
  assign config_accept           = st_r.cfg_acc;
  assign pwm_int_code            = st_r.pwm_int;
  assign pwm_fraction_multiplier = st_r.pwm_dec;
  assign pwm_tick                = st_r.pwm_tick;
  assign step_tick               = st_r.step_tick;
  assign bridges_floating        = st_r.floating;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence read_cmd;
    cmd_req.valid && cmd_req.kind == CMD_READ_STATE;
  endsequence

  sequence cfg_while_running;
    cmd_req.valid && cmd_req.kind == CMD_WRITE_CONFIG &&
    engine.phase != PH_STOPPED;
  endsequence

  a_lockout_after_reset: assert property ( // [RULE_04]
    $past(reset) |-> !state_word[`BIT_LOCKOUT_N])
    else $error("lockout flag not low after reset");

  a_cfg_guard: assert property ( // [RULE_01]
    cfg_while_running |=> !config_accept && state_word[`BIT_CMD_ERR]
      && $stable(pwm_int_code) && $stable(pwm_fraction_multiplier))
    else $error("config write taken while running");

  a_state_write_err: assert property ( // [RULE_17]
    cmd_req.valid && cmd_req.kind == CMD_WRITE_STATE
      |=> state_word[`BIT_CMD_ERR] && !config_accept)
    else $error("state word write did not raise error");

  a_bad_cmd_flag: assert property ( // [RULE_08]
    cmd_req.valid && cmd_req.kind inside {CMD_UNDEFINED, CMD_BLOCKED}
      |=> state_word[`BIT_CMD_ERR])
    else $error("bad command flag not set");

  a_float_exit: assert property ( // [RULE_03]
    cmd_req.valid && cmd_req.kind inside {CMD_MOTION, CMD_HALT}
      && !engine.force_float |=> !bridges_floating && !state_word[0])
    else $error("motion did not leave float state");

  a_float_forced: assert property ( // [RULE_03]
    engine.force_float |=> bridges_floating)
    else $error("forced float not honoured");

  a_fault_latch: assert property ( // [RULE_12]
    !state_word[`BIT_ADC_UV_N] && !(cmd_req.valid &&
      cmd_req.kind == CMD_READ_STATE) |=> !state_word[`BIT_ADC_UV_N])
    else $error("latched flag released without read");

  a_adc_event: assert property ( // [RULE_05]
    engine.adc_uv_evt |=> !state_word[`BIT_ADC_UV_N])
    else $error("adc undervoltage flag not low");

  a_ocd_event: assert property ( // [RULE_06]
    engine.ocd_evt ##1 !(cmd_req.valid && cmd_req.kind == CMD_READ_STATE)
      |-> (!state_word[`BIT_OCD_N])[*2])
    else $error("overcurrent flag not held low");

  a_stall_sep: assert property ( // [RULE_07]
    engine.stall_a_evt && !engine.stall_b_evt && state_word[15]
      && !(cmd_req.valid && cmd_req.kind == CMD_READ_STATE)
      |=> !state_word[14] && state_word[15])
    else $error("stall flags not per bridge");

  a_switch_level: assert property ( // [RULE_09]
    ##3 state_word[`BIT_SW_LEVEL] == !$past(limit_switch_input, 3))
    else $error("switch level mismatch");

  a_switch_event: assert property ( // [RULE_10]
    $fell(limit_switch_input) |-> ##3 state_word[`BIT_SW_EVENT])
    else $error("switch event missed");

  a_live_bits: assert property ( // [RULE_13]
    ##1 state_word[`BIT_BUSY_N] == $past(engine.busy_n)
      && state_word[`BIT_DIR_FWD] == $past(engine.dir_fwd)
      && state_word[`BIT_EXT_STEP] == $past(engine.ext_step_mode)
      && state_word[6:5] == $past(engine.phase))
    else $error("live status bits wrong"); // [RULE_14] [RULE_15] [RULE_16]

  a_thermal_hold: assert property ( // [RULE_11]
    !(cmd_req.valid && cmd_req.kind == CMD_READ_STATE)
      && engine.thermal == TH_DEVICE_OFF
      |=> state_word[12:11] == 2'h3)
    else $error("thermal state not latched");

  a_read_snapshot: assert property ( // [RULE_23]
    read_cmd |=> read_valid && read_data == $past(state_word))
    else $error("read did not return pre-clear word");

  // A config write restarts the accumulator, so it ends the attempt
  a_pwm_fastest: assert property ( // [RULE_18]
    disable iff (reset || config_accept)
    pwm_tick && pwm_int_code == 3'h0 && pwm_fraction_multiplier == 3'h7
      && !config_accept |=> !pwm_tick[*8] ##[1:300] pwm_tick)
    else $error("pwm tick spacing wrong");

endmodule : motor_state_flags
`default_nettype wire

// ===== motor_state_defs.svh
// Bit positions, reset values and PWM constants for the state word block
`ifndef MOTOR_STATE_DEFS_SVH
`define MOTOR_STATE_DEFS_SVH

`define BIT_FLOATING      0
`define BIT_BUSY_N        1
`define BIT_SW_LEVEL      2
`define BIT_SW_EVENT      3
`define BIT_DIR_FWD       4
`define BIT_PHASE_LO      5
`define BIT_CMD_ERR       7
`define BIT_EXT_STEP      8
`define BIT_LOCKOUT_N     9
`define BIT_ADC_UV_N      10
`define BIT_THERM_LO      11
`define BIT_OCD_N         13
`define BIT_STALL_A_N     14
`define BIT_STALL_B_N     15

`define CFG_PWM_INT_LO    13
`define CFG_PWM_DEC_LO    10

`define PWM_INT_RST       3'h0
`define PWM_DEC_RST       3'h3
`define PWM_BASE_DIV      16'h0200
`define PWM_MULT_DEN      16'h0008
`define PWM_INT_MAX_CODE  3'h6

`define STATE_WORD_RST    16'he403

`endif

// ===== motor_state_pkg.sv
// Types shared by the drive state word block and its neighbours
`default_nettype none
package motor_state_pkg;

  typedef enum logic [3:0] {
    CMD_NONE         = 4'h0,
    CMD_READ_STATE   = 4'h1,
    CMD_WRITE_CONFIG = 4'h2,
    CMD_WRITE_STATE  = 4'h3,
    CMD_MOTION       = 4'h4,
    CMD_HALT         = 4'h5,
    CMD_FLOAT        = 4'h6,
    CMD_UNDEFINED    = 4'h7,
    CMD_BLOCKED      = 4'h8
  } cmd_kind_t;

  typedef enum logic [1:0] {
    TH_NORMAL = 2'h0, TH_WARNING = 2'h1, TH_BRIDGE_OFF = 2'h2, TH_DEVICE_OFF = 2'h3
  } thermal_t;

  typedef enum logic [1:0] {
    PH_STOPPED = 2'h0, PH_ACCEL = 2'h1, PH_DECEL = 2'h2, PH_CONSTANT = 2'h3
  } motion_t;

  typedef struct packed {
    logic        valid;
    cmd_kind_t   kind;
    logic [15:0] data;
  } cmd_req_t;

  typedef struct packed {
    logic     lockout_evt;
    logic     adc_uv_evt;
    logic     ocd_evt;
    logic     stall_a_evt;
    logic     stall_b_evt;
    thermal_t thermal;
    logic     busy_n;
    logic     dir_fwd;
    motion_t  phase;
    logic     ext_step_mode;
    logic     force_float;
  } engine_in_t;

endpackage : motor_state_pkg
`default_nettype wire

// ===== motor_host_model.sv
// Host side model: decoded command requests and step pulses
`default_nettype none
module motor_host_model
  import motor_state_pkg::*;
(
  input  wire logic ref_clk,
  output var cmd_req_t cmd_req,
  output logic      step_pulse_input
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cmd_req          = '0;
    step_pulse_input = 1'b0;
  end

  // One-cycle request, launched on an edge and dropped on the next
  task automatic send(input cmd_kind_t kind, input logic [15:0] data);
    @(posedge ref_clk);
    cmd_req <= '{valid: 1'b1, kind: kind, data: data};
    @(posedge ref_clk);
    cmd_req <= '0;
  endtask : send

  // Held two cycles so the two-stage synchroniser cannot miss it
  task automatic step_pulse();
    @(posedge ref_clk);
    step_pulse_input <= 1'b1;
    repeat (2) @(posedge ref_clk);
    step_pulse_input <= 1'b0;
  endtask : step_pulse
endmodule : motor_host_model
`default_nettype wire

// ===== motor_state_flags_bench.sv
// Self-checking bench for the drive state word block
`default_nettype none
module motor_state_flags_bench
  import motor_state_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk;
  logic        reset;
  logic        limit_switch_input;
  engine_in_t  engine;
  cmd_req_t    cmd_req;
  logic        step_pulse_input;
  logic [15:0] state_word;
  logic [15:0] read_data;
  logic        read_valid;
  logic        config_accept;
  logic [2:0]  pwm_int_code;
  logic [2:0]  pwm_fraction_multiplier;
  logic        pwm_tick;
  logic        step_tick;
  logic        bridges_floating;
  logic [15:0] rd;
  int          errors;
  int          checks;
  int          cycles;

  motor_state_flags u_dut (
    .ref_clk(ref_clk), .reset(reset), .cmd_req(cmd_req), .engine(engine),
    .limit_switch_input(limit_switch_input),
    .step_pulse_input(step_pulse_input), .state_word(state_word),
    .read_data(read_data), .read_valid(read_valid),
    .config_accept(config_accept), .pwm_int_code(pwm_int_code),
    .pwm_fraction_multiplier(pwm_fraction_multiplier),
    .pwm_tick(pwm_tick), .step_tick(step_tick),
    .bridges_floating(bridges_floating));

  motor_host_model u_host (
    .ref_clk(ref_clk), .cmd_req(cmd_req),
    .step_pulse_input(step_pulse_input));

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  task automatic end_of_test();
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Longest scenario is the slow PWM setting, about 35k cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      $display("mismatch %0t run did not finish", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, exp, input string msg);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic look(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : look

  task automatic read_state(output logic [15:0] word);
    u_host.send(CMD_READ_STATE, 16'h0000);
    look(0);
    chk(16'(read_valid), 16'h0001, "read pulse missing");
    word = read_data;
    look(2);
  endtask : read_state

  task automatic t_reset();
    look(1);
    chk(state_word, 16'he403, "word after reset");
    chk(16'({pwm_int_code, pwm_fraction_multiplier}), 16'h0003, "pwm reset");
    read_state(rd);
    chk(rd, 16'he403, "read before clear");
    chk(state_word, 16'he603, "lockout not released");
  endtask : t_reset

  task automatic t_commands();
    cmd_kind_t bad [3] = '{CMD_WRITE_STATE, CMD_UNDEFINED, CMD_BLOCKED};
    for (int i = 0; i < 3; i++) begin
      u_host.send(bad[i], 16'hffff);
      look(2);
      chk(state_word, 16'he683, "bad command word");
      read_state(rd);
      chk(rd, 16'he683, "read lost error");
      chk(state_word, 16'he603, "error not cleared");
    end
    @(posedge ref_clk);
    engine.phase <= PH_ACCEL;
    u_host.send(CMD_WRITE_CONFIG, 16'hb400);
    look(0);
    chk(16'(config_accept), 16'h0000, "config taken");
    look(1);
    chk(16'({pwm_int_code, pwm_fraction_multiplier}), 16'h0003, "codes moved");
    chk(state_word, 16'he6a3, "running config word");
    @(posedge ref_clk);
    engine.phase <= PH_STOPPED;
    read_state(rd);
    chk(rd, 16'he683, "read after refused config");
    u_host.send(CMD_WRITE_CONFIG, 16'h5800);
    look(0);
    chk(16'(config_accept), 16'h0001, "config refused");
    look(1);
    chk(16'({pwm_int_code, pwm_fraction_multiplier}), 16'h0016, "codes");
    chk(state_word, 16'he603, "stopped config word");
  endtask : t_commands

  task automatic set_evt(input int b, input logic v);
    case (b)
      9:  engine.lockout_evt <= v;
      10: engine.adc_uv_evt <= v;
      13: engine.ocd_evt <= v;
      14: engine.stall_a_evt <= v;
      default: engine.stall_b_evt <= v;
    endcase
  endtask : set_evt

  task automatic t_events();
    int bits [5] = '{9, 10, 13, 14, 15};
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      set_evt(bits[i], 1'b1);
      @(posedge ref_clk);
      set_evt(bits[i], 1'b0);
      look(6);
      chk(16'(state_word[bits[i]]), 16'h0000, "flag not low");
      read_state(rd);
      chk(16'(rd[bits[i]]), 16'h0000, "read lost flag");
      chk(state_word, 16'he603, "flag not released");
    end
    for (int v = 1; v < 4; v++) begin
      @(posedge ref_clk);
      engine.thermal <= thermal_t'(v);
      look(2);
      chk(16'(state_word[12:11]), 16'(v), "thermal code");
    end
    @(posedge ref_clk);
    engine.thermal <= TH_NORMAL;
    look(4);
    chk(16'(state_word[12:11]), 16'h0003, "thermal not latched");
    read_state(rd);
    chk(state_word, 16'he603, "thermal not released");
  endtask : t_events

  task automatic t_levels();
    @(posedge ref_clk);
    engine.busy_n  <= 1'b0;
    engine.dir_fwd <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      @(posedge ref_clk);
      engine.phase <= motion_t'(p);
      look(2);
      chk(state_word[6:0], 16'({p[1:0], 5'h11}), "levels");
    end
    @(posedge ref_clk);
    engine.phase   <= PH_STOPPED;
    engine.busy_n  <= 1'b1;
    engine.dir_fwd <= 1'b0;
    limit_switch_input <= 1'b0;
    look(6);
    chk(state_word[7:0], 16'h000f, "switch closed");
    @(posedge ref_clk);
    limit_switch_input <= 1'b1;
    look(6);
    chk(state_word[7:0], 16'h000b, "switch open");
    read_state(rd);
    chk(state_word[7:0], 16'h0003, "switch event kept");
  endtask : t_levels

  task automatic t_float();
    cmd_kind_t seq [4] = '{CMD_MOTION, CMD_FLOAT, CMD_HALT, CMD_MOTION};
    logic [1:0] want [4] = '{2'h0, 2'h3, 2'h0, 2'h3};
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        @(posedge ref_clk);
        engine.force_float <= 1'b1;
      end
      u_host.send(seq[i], 16'h0000);
      look(2);
      chk(16'({bridges_floating, state_word[0]}), 16'(want[i]), "float");
    end
    @(posedge ref_clk);
    engine.force_float <= 1'b0;
  endtask : t_float

  task automatic t_step();
    int n;
    @(posedge ref_clk);
    engine.ext_step_mode <= 1'b1;
    u_host.step_pulse();
    n = 0;
    do begin
      look(1);
      n++;
    end while (step_tick !== 1'b1 && n < 8);
    chk(16'(step_tick), 16'h0001, "no step tick");
    chk(16'(state_word[8]), 16'h0001, "step mode flag");
    @(posedge ref_clk);
    engine.ext_step_mode <= 1'b0;
  endtask : t_step

  task automatic wait_tick(output int g);
    g = 0;
    do begin
      look(1);
      g++;
    end while (pwm_tick !== 1'b1 && g < 30000);
  endtask : wait_tick

  // Five periods summed so the fractional averaging cancels out
  task automatic t_pwm();
    logic [5:0] codes [3] = '{6'h07, 6'h3f, 6'h30};
    int want [3] = '{1280, 8960, 28672};
    int g;
    int n;
    for (int i = 0; i < 3; i++) begin
      u_host.send(CMD_WRITE_CONFIG, {codes[i], 10'h000});
      wait_tick(g);
      n = 0;
      for (int k = 0; k < 5; k++) begin
        wait_tick(g);
        n += g;
      end
      chk(16'(n), 16'(want[i]), "pwm period");
    end
  endtask : t_pwm

  initial begin
    errors = 0;
    checks = 0;
    cycles = 0;
    reset = 1'b1;
    limit_switch_input = 1'b1;
    engine = '0;
    engine.busy_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_commands();
    t_events();
    t_levels();
    t_float();
    t_step();
    t_pwm();
    end_of_test();
  end
endmodule : motor_state_flags_bench
`default_nettype wire
